// ### verilog/dgoc_global_ctrl.sv
// global operation control for a four-channel dma controller
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "dgoc_cfg.svh"
// What this block does
// [RULE_01] The global operation register is 16 bits, read and written by software, and resets to all zeros.
// [RULE_02] Reserved bits 15:10 and 7:3 always read as zero and software writes zeros there.
// [RULE_03] Priority codes 00, 01 and 10 grant simultaneous requests in the orders 0123, 0231 and 2013.
// [RULE_04] Priority code 11 selects round-robin arbitration among the four channels.
// [RULE_05] In round robin the channel that just finished a unit becomes lowest and the next one highest.
// [RULE_06] The address error flag is set by hardware when the controller causes an address error.
// [RULE_07] While the address error flag is set every channel is suspended and none is transfer-enabled.
// [RULE_08] Writing one to the address error flag does nothing; a zero clears it only after it was read as one.
// [RULE_09] The nmi flag is set on every nmi input, whether transferring or suspended.
// [RULE_10] While the nmi flag is set transfers on every channel are suspended and prohibited.
// [RULE_11] Writing one to the nmi flag does nothing; a zero clears it only after a read returned one.
// [RULE_12] A channel is transfer-enabled only when the master enable and its own enable are both one.
// [RULE_13] Clearing the master enable during a transfer suspends every channel.
// [RULE_14] With the master enable at zero every channel is disabled whatever its own settings.
// [RULE_15] Even with the master enable set a channel with its end flag set, enable clear or an error flag set stays off.
// [RULE_16] A channel's end flag is set when its transfer count completes and blocks the channel until cleared.
// [RULE_17] Each channel has its own enable, and clearing it during a transfer suspends that channel.
module dgoc_global_ctrl #(
  parameter int N_IRQ = 6
) (
  // clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_reset,
  // register port
  input  dgoc_pkg::dgoc_bus_req_type  i_bus,
  output logic      [15:0]            o_rd_data,
  // transfer engine side
  input  wire logic [3:0]             i_chan_req,
  input  wire logic                   i_unit_done,
  input  wire logic [3:0]             i_count_done,
  input  wire logic                   i_addr_err,
  input  wire logic                   i_nmi,
  // channel control
  output logic      [3:0]             o_chan_enabled,
  output logic      [3:0]             o_grant,
  output logic                        o_suspended,
  // interrupt
  output logic                        o_irq
);
  import dgoc_pkg::*;

  logic              master_enable;
  dgoc_pri_type      priority_sel;
  logic              address_error_flag;
  logic              nmi_seen_flag;
  logic              aerr_armed;
  logic              nmi_armed;
  logic [3:0]        channel_enable;
  logic [3:0]        transfer_end_flag;
  logic [N_IRQ-1:0]  irq_status;
  logic [N_IRQ-1:0]  irq_mask;
  logic [N_IRQ-1:0]  irq_events;
  logic [3:0]        eligible;
  logic              busy;
  logic              wr_global;
  logic              rd_global;
  logic              wr_chan;
  logic              rd_chan;
  logic              wr_stat;
  logic              wr_mask;
  logic [15:0]       global_operation_reg;
  logic [15:0]       channel_control_reg;
  logic [15:0]       next_rd_data;
  localparam logic [15:0] RST_GLOBAL = `DGOC_RST_GLOBAL;

  function automatic logic hit(input logic strobe, input logic [3:0] addr, input logic [3:0] ofs);
    hit = strobe && (addr == ofs);
  endfunction

  assign wr_global = hit(i_bus.wr, i_bus.addr, `DGOC_OFS_GLOBAL);
  assign rd_global = hit(i_bus.rd, i_bus.addr, `DGOC_OFS_GLOBAL);
  assign wr_chan   = hit(i_bus.wr, i_bus.addr, `DGOC_OFS_CHAN);
  assign rd_chan   = hit(i_bus.rd, i_bus.addr, `DGOC_OFS_CHAN);
  assign wr_stat   = hit(i_bus.wr, i_bus.addr, `DGOC_OFS_IRQ_STAT);
  assign wr_mask   = hit(i_bus.wr, i_bus.addr, `DGOC_OFS_IRQ_MASK);

  // reserved positions are tied to zero here, so writes there are simply dropped
  always_comb begin
    global_operation_reg = 16'h0000; // RULE_02
    global_operation_reg[`DGOC_BIT_PRI_HI:`DGOC_BIT_PRI_LO] = priority_sel;
    global_operation_reg[`DGOC_BIT_AERR]   = address_error_flag;
    global_operation_reg[`DGOC_BIT_NMI]    = nmi_seen_flag;
    global_operation_reg[`DGOC_BIT_MASTER] = master_enable;
  end

  always_comb begin
    channel_control_reg = 16'h0000;
    channel_control_reg[3:0] = channel_enable;
    channel_control_reg[`DGOC_BIT_END_BASE +: 4] = transfer_end_flag;
  end

  // writable control fields
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      master_enable <= RST_GLOBAL[`DGOC_BIT_MASTER]; // RULE_01
      priority_sel  <= dgoc_pri_type'(RST_GLOBAL[`DGOC_BIT_PRI_HI:`DGOC_BIT_PRI_LO]);
    end else if (wr_global) begin
      master_enable <= i_bus.wdata[`DGOC_BIT_MASTER]; // RULE_01
      priority_sel  <= dgoc_pri_type'(i_bus.wdata[`DGOC_BIT_PRI_HI:`DGOC_BIT_PRI_LO]);
    end
  end

  // address error flag: a new error wins over a clearing write
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      address_error_flag <= 1'b0;
    end else if (i_addr_err) begin
      address_error_flag <= 1'b1; // RULE_06
    end else if (wr_global && aerr_armed && !i_bus.wdata[`DGOC_BIT_AERR]) begin
      address_error_flag <= 1'b0; // RULE_08
    end
  end

  // nmi flag is set whether or not a transfer is running
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      nmi_seen_flag <= 1'b0;
    end else if (i_nmi) begin
      nmi_seen_flag <= 1'b1; // RULE_09
    end else if (wr_global && nmi_armed && !i_bus.wdata[`DGOC_BIT_NMI]) begin
      nmi_seen_flag <= 1'b0; // RULE_11
    end
  end

  // a read that saw a one arms the clear; any write to the global register consumes the arming
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      aerr_armed <= 1'b0;
      nmi_armed  <= 1'b0;
    end else if (wr_global) begin
      aerr_armed <= 1'b0; // RULE_08
      nmi_armed  <= 1'b0; // RULE_11
    end else if (rd_global) begin
      aerr_armed <= aerr_armed | address_error_flag;
      nmi_armed  <= nmi_armed | nmi_seen_flag;
    end
  end

  dgoc_chan_flags #(
    .N (4)
  ) u_chan_flags (
    .i_ref_clk    (i_ref_clk),
    .i_reset      (i_reset),
    .i_wr_hit     (wr_chan),
    .i_rd_hit     (rd_chan),
    .i_wdata      (i_bus.wdata),
    .i_count_done (i_count_done),
    .o_enable     (channel_enable),
    .o_end_flag   (transfer_end_flag)
  );

  // combinational gating so a suspend takes hold in the same cycle
  assign o_suspended    = !master_enable || address_error_flag || nmi_seen_flag; // RULE_13
  assign o_chan_enabled = {4{master_enable}} & channel_enable // RULE_12
                        & {4{!address_error_flag && !nmi_seen_flag}} // RULE_07 RULE_10
                        & ~transfer_end_flag; // RULE_15
  assign eligible       = o_chan_enabled & i_chan_req; // RULE_14

  dgoc_arbiter u_arbiter (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_mode      (priority_sel),
    .i_eligible  (eligible),
    .i_unit_done (i_unit_done),
    .o_grant     (o_grant),
    .o_busy      (busy)
  );

  // interrupt status: events set, write one clears, set wins
  assign irq_events = {i_count_done, i_nmi, i_addr_err};

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_status <= `DGOC_RST_MASK;
    end else if (wr_stat) begin
      irq_status <= (irq_status & ~i_bus.wdata[N_IRQ-1:0]) | irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_mask <= `DGOC_RST_MASK;
    end else if (wr_mask) begin
      irq_mask <= i_bus.wdata[N_IRQ-1:0];
    end
  end

  assign o_irq = |(irq_status & irq_mask);

  // read data is valid only in the cycle after the read strobe
  always_comb begin
    next_rd_data = 16'h0000;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        `DGOC_OFS_GLOBAL:   next_rd_data = global_operation_reg;
        `DGOC_OFS_CHAN:     next_rd_data = channel_control_reg;
        `DGOC_OFS_IRQ_STAT: next_rd_data = 16'(irq_status);
        `DGOC_OFS_IRQ_MASK: next_rd_data = 16'(irq_mask);
        default:            next_rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rd_data <= 16'h0000;
    end else begin
      o_rd_data <= next_rd_data;
    end
  end

  property p_ctrl_write;
    @(posedge i_ref_clk) disable iff (i_reset)
    wr_global |=> (master_enable == $past(i_bus.wdata[0])) && (priority_sel == $past(i_bus.wdata[9:8]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored"); // RULE_01

  property p_reserved;
    @(posedge i_ref_clk) disable iff (i_reset)
    rd_global |=> (o_rd_data[15:10] == 6'h00) && (o_rd_data[7:3] == 5'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero"); // RULE_02

  property p_aerr_set;
    @(posedge i_ref_clk) disable iff (i_reset)
    i_addr_err |=> address_error_flag ##1 (o_chan_enabled == 4'h0);
  endproperty
  a_aerr_set: assert property (p_aerr_set) else $error("address error did not stop channels"); // RULE_06

  property p_error_blocks;
    @(posedge i_ref_clk) disable iff (i_reset)
    (address_error_flag || nmi_seen_flag) |-> (o_chan_enabled == 4'h0) && (o_grant == 4'h0 || busy) ##1 (o_grant == 4'h0);
  endproperty
  a_error_blocks: assert property (p_error_blocks) else $error("channel live under error flag"); // RULE_07

  property p_aerr_one_ignored;
    @(posedge i_ref_clk) disable iff (i_reset)
    (wr_global && i_bus.wdata[2] && !address_error_flag && !i_addr_err) |=> !address_error_flag;
  endproperty
  a_aerr_one_ignored: assert property (p_aerr_one_ignored) else $error("one write set address error"); // RULE_08

  property p_aerr_clear;
    @(posedge i_ref_clk) disable iff (i_reset)
    (rd_global && address_error_flag && !i_addr_err) ##1 (!wr_global && !i_addr_err)
    ##1 (wr_global && !i_bus.wdata[2] && !i_addr_err)
    |=> !address_error_flag;
  endproperty
  a_aerr_clear: assert property (p_aerr_clear) else $error("read then zero write did not clear"); // RULE_08

  property p_nmi_set;
    @(posedge i_ref_clk) disable iff (i_reset)
    i_nmi |=> nmi_seen_flag && o_suspended;
  endproperty
  a_nmi_set: assert property (p_nmi_set) else $error("nmi flag not set"); // RULE_09

  property p_nmi_needs_read;
    @(posedge i_ref_clk) disable iff (i_reset)
    (nmi_seen_flag && !nmi_armed && wr_global) |=> nmi_seen_flag;
  endproperty
  a_nmi_needs_read: assert property (p_nmi_needs_read) else $error("nmi cleared without read"); // RULE_11

  property p_enable_and;
    @(posedge i_ref_clk) disable iff (i_reset)
    (o_chan_enabled & ~(channel_enable & {4{master_enable}})) == 4'h0;
  endproperty
  a_enable_and: assert property (p_enable_and) else $error("channel enabled without both enables"); // RULE_12

  property p_master_off;
    @(posedge i_ref_clk) disable iff (i_reset)
    (busy && wr_global && !i_bus.wdata[0]) |=> (o_chan_enabled == 4'h0) ##1 (o_grant == 4'h0);
  endproperty
  a_master_off: assert property (p_master_off) else $error("master clear did not suspend"); // RULE_13

  property p_end_blocks;
    @(posedge i_ref_clk) disable iff (i_reset)
    (o_chan_enabled & transfer_end_flag) == 4'h0;
  endproperty
  a_end_blocks: assert property (p_end_blocks) else $error("ended channel still enabled"); // RULE_15

  property p_nmi_blocks;
    @(posedge i_ref_clk) disable iff (i_reset)
    nmi_seen_flag |-> o_suspended && (o_chan_enabled == 4'h0);
  endproperty
  a_nmi_blocks: assert property (p_nmi_blocks) else $error("nmi flag left a channel enabled"); // RULE_10

  property p_master_zero;
    @(posedge i_ref_clk) disable iff (i_reset)
    !master_enable |-> o_suspended && (o_chan_enabled == 4'h0) && (eligible == 4'h0);
  endproperty
  a_master_zero: assert property (p_master_zero) else $error("channel live with master enable clear"); // RULE_14

  property p_aerr_sticky;
    @(posedge i_ref_clk) disable iff (i_reset)
    (address_error_flag && !wr_global) |=> address_error_flag;
  endproperty
  a_aerr_sticky: assert property (p_aerr_sticky) else $error("address error flag dropped"); // RULE_08

  property p_nmi_one_ignored;
    @(posedge i_ref_clk) disable iff (i_reset)
    (wr_global && i_bus.wdata[1] && !nmi_seen_flag && !i_nmi) |=> !nmi_seen_flag;
  endproperty
  a_nmi_one_ignored: assert property (p_nmi_one_ignored) else $error("one write set nmi flag"); // RULE_11

  property p_nmi_clear;
    @(posedge i_ref_clk) disable iff (i_reset)
    (rd_global && nmi_seen_flag && !i_nmi) ##1 (!wr_global && !i_nmi)
    ##1 (wr_global && !i_bus.wdata[1] && !i_nmi) |=> !nmi_seen_flag;
  endproperty
  a_nmi_clear: assert property (p_nmi_clear) else $error("read then zero write left nmi flag"); // RULE_11

  property p_rd_idle;
    @(posedge i_ref_clk) disable iff (i_reset)
    !i_bus.rd |=> (o_rd_data == 16'h0000);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data held past its cycle"); // RULE_01

  property p_irq_event;
    @(posedge i_ref_clk) disable iff (i_reset)
    (|irq_events) |=> ((irq_status & $past(irq_events)) == $past(irq_events));
  endproperty
  a_irq_event: assert property (p_irq_event) else $error("event lost from interrupt status"); // RULE_09

  property p_grant_enabled;
    @(posedge i_ref_clk) disable iff (i_reset)
    (o_grant != 4'h0) |-> ((o_grant & $past(o_chan_enabled)) == o_grant);
  endproperty
  a_grant_enabled: assert property (p_grant_enabled) else $error("grant to a disabled channel"); // RULE_12

  property p_chan_clear;
    @(posedge i_ref_clk) disable iff (i_reset)
    wr_chan |=> ((o_chan_enabled & ~$past(i_bus.wdata[3:0])) == 4'h0);
  endproperty
  a_chan_clear: assert property (p_chan_clear) else $error("cleared channel still enabled"); // RULE_17

  c_grant_fixed: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    priority_sel == PRI_0123 && busy && i_unit_done);
  c_nmi_clear: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    nmi_seen_flag ##1 !nmi_seen_flag);
  c_irq: cover property (@(posedge i_ref_clk) disable iff (i_reset) $rose(o_irq));
endmodule // dgoc_global_ctrl

// ### verilog/dgoc_cfg.svh
// offsets, field positions and reset values of the global operation control block
`ifndef DGOC_CFG_SVH
`define DGOC_CFG_SVH
`define DGOC_OFS_GLOBAL    4'h0
`define DGOC_OFS_CHAN      4'h1
`define DGOC_OFS_IRQ_STAT  4'h2
`define DGOC_OFS_IRQ_MASK  4'h3
`define DGOC_BIT_MASTER    0
`define DGOC_BIT_NMI       1
`define DGOC_BIT_AERR      2
`define DGOC_BIT_PRI_LO    8
`define DGOC_BIT_PRI_HI    9
`define DGOC_BIT_END_BASE  4
`define DGOC_IRQ_AERR      0
`define DGOC_IRQ_NMI       1
`define DGOC_IRQ_END_BASE  2
`define DGOC_RST_GLOBAL    16'h0000
`define DGOC_RST_MASK      6'h00
`define DGOC_RST_RR_LAST   2'h3
`endif

// ### verilog/dgoc_pkg.sv
// types shared by the global operation control block
package dgoc_pkg;
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } dgoc_bus_req_type;

  typedef enum logic [1:0] {
    PRI_0123  = 2'h0,
    PRI_0231  = 2'h1,
    PRI_2013  = 2'h2,
    PRI_ROUND = 2'h3
  } dgoc_pri_type;

  typedef enum logic [1:0] {
    ARB_IDLE = 2'h1,
    ARB_BUSY = 2'h2
  } dgoc_arb_state_type;
endpackage

// ### verilog/dgoc_chan_flags.sv
// per-channel enable bits and transfer-end flags
`timescale 1ns/1ps
`include "dgoc_cfg.svh"
module dgoc_chan_flags #(
  parameter int N = 4
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset,
  // register access
  input  wire logic         i_wr_hit,
  input  wire logic         i_rd_hit,
  input  wire logic [15:0]  i_wdata,
  // engine events
  input  wire logic [N-1:0] i_count_done,
  // state
  output logic      [N-1:0] o_enable,
  output logic      [N-1:0] o_end_flag
);
  import dgoc_pkg::*;

  logic [N-1:0] armed;

  for (genvar i = 0; i < N; i++) begin : g_chan
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
        o_enable[i] <= 1'b0;
      end else if (i_wr_hit) begin
        o_enable[i] <= i_wdata[i]; // RULE_17
      end
    end

    // only a zero written after a read of one clears; a new end wins
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
        o_end_flag[i] <= 1'b0;
      end else if (i_count_done[i]) begin
        o_end_flag[i] <= 1'b1; // RULE_16
      end else if (i_wr_hit && armed[i] && !i_wdata[`DGOC_BIT_END_BASE + i]) begin
        o_end_flag[i] <= 1'b0;
      end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
        armed[i] <= 1'b0;
      end else if (i_wr_hit) begin
        armed[i] <= 1'b0;
      end else if (i_rd_hit && o_end_flag[i]) begin
        armed[i] <= 1'b1;
      end
    end
  end

  property p_end_set;
    @(posedge i_ref_clk) disable iff (i_reset)
    (|i_count_done) |=> ((o_end_flag & $past(i_count_done)) == $past(i_count_done));
  endproperty
  a_end_set: assert property (p_end_set) else $error("end flag not set"); // RULE_16

  property p_en_write;
    @(posedge i_ref_clk) disable iff (i_reset)
    i_wr_hit |=> (o_enable == $past(i_wdata[N-1:0]));
  endproperty
  a_en_write: assert property (p_en_write) else $error("channel enable not stored"); // RULE_17
endmodule // dgoc_chan_flags

// ### verilog/dgoc_arbiter.sv
// channel arbiter: three fixed orders and round robin
`timescale 1ns/1ps
`include "dgoc_cfg.svh"
module dgoc_arbiter (
  // clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset,
  // control
  input  dgoc_pkg::dgoc_pri_type     i_mode,
  input  wire logic [3:0]            i_eligible,
  input  wire logic                  i_unit_done,
  // grant
  output logic      [3:0]            o_grant,
  output logic                       o_busy
);
  import dgoc_pkg::*;

  dgoc_arb_state_type state;
  logic [1:0]         rr_last;

  // order packed highest first in the top two bits
  function automatic logic [7:0] order_of(input dgoc_pri_type m, input logic [1:0] last);
    unique case (m)
      PRI_0123:  order_of = {2'h0, 2'h1, 2'h2, 2'h3}; // RULE_03
      PRI_0231:  order_of = {2'h0, 2'h2, 2'h3, 2'h1}; // RULE_03
      PRI_2013:  order_of = {2'h2, 2'h0, 2'h1, 2'h3}; // RULE_03
      PRI_ROUND: order_of = {2'(last + 2'h1), 2'(last + 2'h2), 2'(last + 2'h3), last}; // RULE_04
    endcase
  endfunction

  function automatic logic [3:0] pick(input logic [3:0] req, input logic [7:0] ord);
    logic [1:0] ch;
    pick = 4'h0;
    for (int k = 3; k >= 0; k--) begin
      ch = ord[2*k +: 2];
      if (pick == 4'h0 && req[ch]) begin
        pick = 4'(4'h1 << ch);
      end
    end
  endfunction

  function automatic logic [1:0] index_of(input logic [3:0] g);
    index_of = g[3] ? 2'h3 : g[2] ? 2'h2 : g[1] ? 2'h1 : 2'h0;
  endfunction

  assign o_busy = (state == ARB_BUSY);

  // a grant is dropped on the clock edge after its channel loses eligibility
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state   <= ARB_IDLE;
      o_grant <= 4'h0;
    end else begin
      unique case (state)
        ARB_IDLE: begin
          if (|i_eligible) begin
            state   <= ARB_BUSY;
            o_grant <= pick(i_eligible, order_of(i_mode, rr_last));
          end
        end
        ARB_BUSY: begin
          if (i_unit_done || ((o_grant & i_eligible) == 4'h0)) begin
            state   <= ARB_IDLE;
            o_grant <= 4'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      rr_last <= `DGOC_RST_RR_LAST;
    end else if (o_busy && i_unit_done && i_mode == PRI_ROUND) begin
      rr_last <= index_of(o_grant); // RULE_05
    end
  end

  property p_onehot;
    @(posedge i_ref_clk) disable iff (i_reset)
    $onehot0(o_grant) && (o_busy == (o_grant != 4'h0));
  endproperty
  a_onehot: assert property (p_onehot) else $error("grant not one-hot"); // RULE_03

  property p_fixed_0231;
    @(posedge i_ref_clk) disable iff (i_reset)
    (!o_busy && i_mode == PRI_0231 && !i_eligible[0] && i_eligible[2]) |=> (o_grant == 4'h4);
  endproperty
  a_fixed_0231: assert property (p_fixed_0231) else $error("order 0,2,3,1 broken"); // RULE_03

  property p_fixed_2013;
    @(posedge i_ref_clk) disable iff (i_reset)
    (!o_busy && i_mode == PRI_2013 && i_eligible[2]) |=> (o_grant == 4'h4);
  endproperty
  a_fixed_2013: assert property (p_fixed_2013) else $error("order 2,0,1,3 broken"); // RULE_03

  property p_round;
    @(posedge i_ref_clk) disable iff (i_reset)
    (o_busy && i_unit_done && i_mode == PRI_ROUND && o_grant[0]) ##1
    (!o_busy && i_mode == PRI_ROUND && i_eligible[0] && i_eligible[1]) |=> (o_grant == 4'h2);
  endproperty
  a_round: assert property (p_round) else $error("round robin did not rotate"); // RULE_05

  c_round: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    o_busy && i_unit_done && i_mode == PRI_ROUND ##2 o_busy);
endmodule // dgoc_arbiter

// ### verification/tb_top.sv
// self-checking testbench for the global operation control block
`timescale 1ns/1ps
module tb_top;
  import dgoc_pkg::*;
  logic             i_ref_clk;
  logic             i_reset;
  dgoc_bus_req_type bus;
  logic [15:0]      o_rd_data;
  logic [3:0]       chan_req;
  logic             unit_done;
  logic [3:0]       count_done;
  logic             addr_err;
  logic             nmi;
  logic [3:0]       o_chan_enabled;
  logic [3:0]       o_grant;
  logic             o_suspended;
  logic             o_irq;
  int               errors;
  int               checks_done;
  logic [35:0]      rows [0:7];
  logic [3:0]       pexp [0:5];
  logic [15:0]      rd_val;
  logic [15:0]      fb;

  dgoc_global_ctrl dut (
    .i_ref_clk      (i_ref_clk),
    .i_reset        (i_reset),
    .i_bus          (bus),
    .o_rd_data      (o_rd_data),
    .i_chan_req     (chan_req),
    .i_unit_done    (unit_done),
    .i_count_done   (count_done),
    .i_addr_err     (addr_err),
    .i_nmi          (nmi),
    .o_chan_enabled (o_chan_enabled),
    .o_grant        (o_grant),
    .o_suspended    (o_suspended),
    .o_irq          (o_irq)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bus cycles end on a falling edge so that checks see settled outputs
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_ref_clk);
    bus.wr <= 1'b0;
    @(negedge i_ref_clk);
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge i_ref_clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_ref_clk);
    bus.rd <= 1'b0;
    @(negedge i_ref_clk);
    rd_val = o_rd_data;
  endtask

  // bounded wait; a grant that never comes shows up as a mismatch
  task automatic wait_grant(input logic [3:0] exp);
    int n;
    n = 0;
    @(negedge i_ref_clk);
    while (o_grant === 4'h0 && n < 8) begin
      @(negedge i_ref_clk);
      n++;
    end
    chk({12'h000, o_grant}, {12'h000, exp});
    if (o_grant === 4'h0) begin
      tally_and_finish();
    end
  endtask

  // one-cycle event pulse: 0 address error, 1 nmi, 2..5 count done
  task automatic ev(input int k);
    @(posedge i_ref_clk);
    if (k == 0) addr_err <= 1'b1;
    else if (k == 1) nmi <= 1'b1;
    else count_done[k-2] <= 1'b1;
    @(posedge i_ref_clk);
    addr_err   <= 1'b0;
    nmi        <= 1'b0;
    count_done <= 4'h0;
  endtask

  task automatic pulse_done;
    @(posedge i_ref_clk);
    unit_done <= 1'b1;
    @(posedge i_ref_clk);
    unit_done <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    errors = 0;
    checks_done = 0;
    bus = '0;
    chan_req = 4'h0;
    unit_done = 1'b0;
    count_done = 4'h0;
    addr_err = 1'b0;
    nmi = 1'b0;
    i_reset = 1'b1;
    // address, write data, expected read back
    rows = '{{4'h0, 16'h0307, 16'h0301}, {4'h0, 16'h0000, 16'h0000}, {4'h1, 16'hFFFF, 16'h000F},
             {4'h1, 16'h0005, 16'h0005}, {4'h3, 16'hFFFF, 16'h003F}, {4'h3, 16'h0000, 16'h0000},
             {4'h2, 16'hFFFF, 16'h0000}, {4'h7, 16'hFFFF, 16'h0000}};
    pexp = '{4'h2, 4'h2, 4'h8, 4'h4, 4'h2, 4'h4};
    repeat (6) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd(a[3:0]);
      chk(rd_val, 16'h0000);
    end
    chk({15'h0000, o_suspended}, 16'h0001);
    foreach (rows[i]) begin
      wr(rows[i][35:32], rows[i][31:16]);
      rd(rows[i][35:32]);
      chk(rd_val, rows[i][15:0]);
    end
    wr(4'h0, 16'h0001);
    chk({12'h000, o_chan_enabled}, 16'h0005);
    wr(4'h1, 16'h0000);
    chk({12'h000, o_chan_enabled}, 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h000F);
    chk({12'h000, o_chan_enabled}, 16'h0000);
    // fixed orders with two request patterns each
    for (int k = 0; k < 6; k++) begin
      wr(4'h0, {6'h00, k[2:1], 8'h01});
      @(posedge i_ref_clk);
      chan_req <= k[0] ? 4'hE : 4'hA;
      wait_grant(pexp[k]);
      @(posedge i_ref_clk);
      chan_req <= 4'h0;
      unit_done <= 1'b1;
      @(posedge i_ref_clk);
      unit_done <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
    end
    wr(4'h0, 16'h0301);
    @(posedge i_ref_clk);
    chan_req <= 4'hF;
    for (int k = 0; k < 5; k++) begin
      wait_grant(4'h1 << k[1:0]);
      pulse_done();
    end
    chan_req <= 4'h0;
    wr(4'h0, 16'h0001);
    @(posedge i_ref_clk);
    chan_req <= 4'h1;
    wait_grant(4'h1);
    wr(4'h0, 16'h0000);
    chk({15'h0000, o_suspended}, 16'h0001);
    @(negedge i_ref_clk);
    chk({12'h000, o_grant}, 16'h0000);
    wr(4'h0, 16'h0001);
    // flags: the read that sees a one arms the clearing zero write
    for (int f = 0; f < 2; f++) begin
      fb = f ? 16'h0002 : 16'h0004;
      wait_grant(4'h1);
      ev(f);
      @(negedge i_ref_clk);
      chk({11'h000, o_suspended, o_chan_enabled}, 16'h0010);
      @(negedge i_ref_clk);
      chk({11'h000, o_irq, o_grant}, 16'h0000);
      wr(4'h3, 16'h003F);
      chk({15'h0000, o_irq}, 16'h0001);
      wr(4'h0, 16'h0001);
      rd(4'h0);
      chk(rd_val, 16'h0001 | fb);
      wr(4'h0, 16'h0001 | fb);
      rd(4'h0);
      chk(rd_val, 16'h0001 | fb);
      wr(4'h0, 16'h0001);
      rd(4'h0);
      chk(rd_val, 16'h0001);
      rd(4'h2);
      chk(rd_val, f ? 16'h0002 : 16'h0001);
      wr(4'h2, 16'h003F);
      chk({15'h0000, o_irq}, 16'h0000);
      wr(4'h3, 16'h0000);
    end
    // nmi while suspended
    wr(4'h0, 16'h0000);
    ev(1);
    rd(4'h0);
    chk(rd_val, 16'h0002);
    wr(4'h0, 16'h0001);
    wr(4'h2, 16'h003F);
    chk({12'h000, o_chan_enabled}, 16'h000F);
    // transfer end on channel 1
    ev(3);
    @(negedge i_ref_clk);
    chk({12'h000, o_chan_enabled}, 16'h000D);
    rd(4'h2);
    chk(rd_val, 16'h0008);
    rd(4'h1);
    chk(rd_val, 16'h002F);
    wr(4'h1, 16'h000F);
    rd(4'h1);
    chk(rd_val, 16'h000F);
    // mid-run reset with a channel still requesting
    @(posedge i_ref_clk);
    i_reset <= 1'b1;
    @(posedge i_ref_clk);
    i_reset <= 1'b0;
    @(negedge i_ref_clk);
    chk({6'h00, o_irq, o_suspended, o_grant, o_chan_enabled}, 16'h0100);
    rd(4'h1);
    chk(rd_val, 16'h0000);
    tally_and_finish();
  end
endmodule // tb_top
